// [scs_clock_ctrl.sv]
`timescale 1ns/1ps
module scs_clock_ctrl #(
   parameter int ADDR_W = 8
) (
   input  wire logic              CLOCK,            // 50 MHz system clock
   input  wire logic              RST,              // Asynchronous reset, active high
   input  wire logic              PSEL,             // APB select
   input  wire logic              PENABLE,          // APB access phase
   input  wire logic              PWRITE,           // APB direction
   input  wire logic [ADDR_W-1:0] PADDR,            // APB byte address
   input  wire logic [31:0]       PWDATA,           // APB write data
   input  wire logic [3:0]        PSTRB,            // APB byte strobes
   output logic                   PREADY,           // APB ready
   output logic [31:0]            PRDATA,           // APB read data
   output logic                   PSLVERR,          // APB error on unmapped address
   input  wire logic [2:0]        BOOT_OPT,         // Boot calibration strap
   input  wire logic              FAST_RC_CLK,      // Fast RC oscillator output
   input  wire logic              SLOW_RC_CLK,      // Slow RC oscillator output
   input  wire logic              XTAL_CLK,         // Crystal oscillator output
   output logic                   FAST_RC_EN,       // Fast RC oscillator enable
   output logic                   SLOW_RC_EN,       // Slow RC oscillator enable
   output logic                   XTAL_EN,          // Crystal oscillator enable
   output logic [1:0]             XTAL_DRIVE,       // Crystal drive strength
   output logic                   XTAL_LOW_CURRENT, // Crystal low-current mode
   output logic                   WDT_EN,           // Watchdog enable
   output logic                   FAST_RC_CAL,      // Fast RC calibration applied
   output logic [1:0]             SYS_SRC,          // Active system clock source
   output logic                   SYS_CLK_EN        // One pulse per system clock
);

   logic [7:0]  clksel_r;
   logic [7:0]  xtal_ctrl_r;
   logic [7:0]  misc_r;
   logic        wdt_r;
   logic        fast_cal_r;
   logic [2:0]  osc_s1_r;
   logic [2:0]  osc_s2_r;
   logic [2:0]  osc_prev_r;
   logic [2:0]  boot_opt_s1_r;
   logic [2:0]  boot_opt_s2_r;
   logic [4:0]  div_cnt_r;
   logic [4:0]  div_cnt_nxt;
   logic        restart_r;
   logic        pulse_nxt;
   logic        src_edge;
   logic        src_on;
   logic [5:0]  div_ratio;
   logic [2:0]  div_code;
   scs_pkg::scs_src_t src;
   logic [8:0]  sel_dec;
   logic        hit_clksel;
   logic        hit_xtal;
   logic        hit_misc;
   logic        hit_status;
   logic        mapped;
   logic        setup;
   logic        wr_en;
   logic [7:0]  rd_val;
   logic [7:0]  status;

   typedef enum logic [0:0] {BOOT_LOAD, BOOT_DONE} scs_boot_t;
   scs_boot_t boot_r;

   // Source and divider from the select value
   function automatic logic [8:0] decode_sel(input logic [7:0] sel);
      logic [3:0] key;
      key = {sel[7:5], sel[3]};
      case (key)
         scs_pkg::KEY_FAST_DIV2:  decode_sel = {3'h1, scs_pkg::DIV_2};
         scs_pkg::KEY_FAST_DIV4:  decode_sel = {3'h2, scs_pkg::DIV_4};
         scs_pkg::KEY_FAST_DIV8:  decode_sel = {3'h3, scs_pkg::DIV_8};
         scs_pkg::KEY_FAST_DIV16: decode_sel = {3'h4, scs_pkg::DIV_16};
         scs_pkg::KEY_FAST_DIV32: decode_sel = {3'h5, scs_pkg::DIV_32};
         scs_pkg::KEY_XTAL:       decode_sel = {3'h6, scs_pkg::DIV_1};
         default:                 decode_sel = {3'h0, scs_pkg::DIV_1};
      endcase
   endfunction

   assign sel_dec   = decode_sel(clksel_r);
   assign div_code  = sel_dec[8:6];
   assign div_ratio = sel_dec[5:0];

   always_comb begin
      case (div_code)
         3'h0:    src = scs_pkg::SRC_SLOW;
         3'h6:    src = scs_pkg::SRC_XTAL;
         default: src = scs_pkg::SRC_FAST;
      endcase
   end

   // APB decode
   assign hit_clksel = PADDR[7:0] == scs_pkg::byte_addr(scs_pkg::CLKSEL_IDX);
   assign hit_xtal   = PADDR[7:0] == scs_pkg::byte_addr(scs_pkg::XTAL_CTRL_IDX);
   assign hit_misc   = PADDR[7:0] == scs_pkg::byte_addr(scs_pkg::MISC_IDX);
   assign hit_status = PADDR[7:0] == scs_pkg::byte_addr(scs_pkg::STATUS_IDX);
   assign mapped     = hit_clksel | hit_xtal | hit_misc | hit_status;
   assign setup      = PSEL & ~PENABLE;
   assign wr_en      = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR & PSTRB[0];

   always_comb begin
      status = 8'h00;
      status[scs_pkg::STAT_SRC_LO +: 2] = 2'(src);
      status[scs_pkg::STAT_DIV_LO +: 3] = div_code;
      status[scs_pkg::STAT_STOPPED]     = ~src_on;
      status[scs_pkg::STAT_BOOTED]      = boot_r == BOOT_DONE;
      status[scs_pkg::STAT_FAST_CAL]    = fast_cal_r;
   end

   always_comb begin
      rd_val = 8'h00;
      if (hit_clksel) begin
         rd_val = clksel_r;
      end else if (hit_xtal) begin
         rd_val = xtal_ctrl_r;
      end else if (hit_misc) begin
         rd_val = misc_r;
      end else if (hit_status) begin
         rd_val = status;
      end
   end

   // Zero-wait answer prepared in the setup cycle
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup & ~mapped;
         if (setup & ~PWRITE) begin
            PRDATA <= {24'h00_0000, rd_val};
         end
      end
   end

   // Strap pin is foreign to CLOCK; unreset so it is settled when reset lifts
   always_ff @(posedge CLOCK) begin
      boot_opt_s1_r <= BOOT_OPT;
      boot_opt_s2_r <= boot_opt_s1_r;
   end

   // Boot: strap captured once after reset release
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         boot_r <= BOOT_LOAD;
      end else begin
         case (boot_r)
            BOOT_LOAD: boot_r <= BOOT_DONE;
            BOOT_DONE: boot_r <= BOOT_DONE;
            default:   boot_r <= BOOT_DONE;
         endcase
      end
   end

   // Clock select register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         clksel_r <= scs_pkg::CLKSEL_RST;
      end else if (boot_r == BOOT_LOAD) begin
         case (boot_opt_s2_r)
            scs_pkg::BOOT_FAST_DIV2:  clksel_r <= scs_pkg::SEL_FAST_DIV2;
            scs_pkg::BOOT_FAST_DIV4:  clksel_r <= scs_pkg::SEL_FAST_DIV4;
            scs_pkg::BOOT_FAST_DIV8:  clksel_r <= scs_pkg::SEL_FAST_DIV8;
            scs_pkg::BOOT_FAST_DIV16: clksel_r <= scs_pkg::SEL_FAST_DIV16;
            scs_pkg::BOOT_FAST_DIV32: clksel_r <= scs_pkg::SEL_FAST_DIV32;
            scs_pkg::BOOT_SLOW:       clksel_r <= scs_pkg::SEL_SLOW;
            default:                  clksel_r <= clksel_r;
         endcase
      end else if (wr_en & hit_clksel) begin
         // A write with PSTRB[0] set takes effect at once
         clksel_r <= PWDATA[7:0];
      end
   end

   // Fast RC held off until calibrated or software writes the select
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         fast_cal_r <= 1'b0;
      end else if (boot_r == BOOT_LOAD) begin
         // Uncalibrated boot keeps fast RC off
         fast_cal_r <= (boot_opt_s2_r <= scs_pkg::BOOT_SLOW);
      end else if (wr_en & hit_clksel) begin
         fast_cal_r <= 1'b1;
      end
   end

   // Watchdog enable
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         wdt_r <= 1'b1;
      end else if (boot_r == BOOT_LOAD) begin
         wdt_r <= (boot_opt_s2_r >= scs_pkg::BOOT_SLOW);
      end else if (wr_en & hit_misc) begin
         wdt_r <= PWDATA[scs_pkg::MISC_WDT_BIT];
      end
   end

   // Crystal control and misc registers
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         xtal_ctrl_r <= scs_pkg::XTAL_CTRL_RST;
         misc_r      <= scs_pkg::MISC_RST;
      end else begin
         if (wr_en & hit_xtal) begin
            xtal_ctrl_r <= PWDATA[7:0];
         end
         if (wr_en & hit_misc) begin
            misc_r <= PWDATA[7:0];
         end
      end
   end

   // Oscillator controls
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         FAST_RC_EN       <= 1'b0;
         SLOW_RC_EN       <= 1'b1;
         XTAL_EN          <= 1'b0;
         XTAL_DRIVE       <= 2'b00;
         XTAL_LOW_CURRENT <= 1'b0;
         WDT_EN           <= 1'b1;
         FAST_RC_CAL      <= 1'b0;
         SYS_SRC          <= 2'(scs_pkg::SRC_SLOW);
      end else begin
         FAST_RC_EN       <= clksel_r[scs_pkg::CLKSEL_FAST_EN] & fast_cal_r;
         SLOW_RC_EN       <= clksel_r[scs_pkg::CLKSEL_SLOW_EN];
         XTAL_EN          <= xtal_ctrl_r[scs_pkg::XTAL_EN_BIT];
         XTAL_DRIVE       <= xtal_ctrl_r[scs_pkg::XTAL_DRV_HI:scs_pkg::XTAL_DRV_LO];
         // Low current only while crystal runs
         XTAL_LOW_CURRENT <= misc_r[scs_pkg::MISC_LOWCUR_BIT]
                             & xtal_ctrl_r[scs_pkg::XTAL_EN_BIT];
         WDT_EN           <= wdt_r;
         FAST_RC_CAL      <= fast_cal_r;
         // Selected source regardless of fast enable
         SYS_SRC          <= 2'(src);
      end
   end

   // Oscillator outputs are foreign to CLOCK
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         osc_s1_r   <= 3'b000;
         osc_s2_r   <= 3'b000;
         osc_prev_r <= 3'b000;
      end else begin
         osc_s1_r   <= {XTAL_CLK, FAST_RC_CLK, SLOW_RC_CLK};
         osc_s2_r   <= osc_s1_r;
         osc_prev_r <= osc_s2_r;
      end
   end

   // Rising edge and enable of the selected oscillator
   always_comb begin
      case (src)
         scs_pkg::SRC_FAST: begin
            src_edge = osc_s2_r[1] & ~osc_prev_r[1];
            src_on   = clksel_r[scs_pkg::CLKSEL_FAST_EN] & fast_cal_r;
         end
         scs_pkg::SRC_XTAL: begin
            src_edge = osc_s2_r[2] & ~osc_prev_r[2];
            src_on   = xtal_ctrl_r[scs_pkg::XTAL_EN_BIT];
         end
         default: begin
            src_edge = osc_s2_r[0] & ~osc_prev_r[0];
            src_on   = clksel_r[scs_pkg::CLKSEL_SLOW_EN];
         end
      endcase
   end

   // A stopped selected source simply yields no clock pulses
   always_comb begin
      div_cnt_nxt = div_cnt_r;
      pulse_nxt   = 1'b0;
      if (restart_r) begin
         div_cnt_nxt = 5'h00;
      end else if (src_edge & src_on) begin
         if (div_cnt_r == 5'(div_ratio - 6'h01)) begin
            div_cnt_nxt = 5'h00;
            pulse_nxt   = 1'b1;
         end else begin
            div_cnt_nxt = div_cnt_r + 5'h01;
         end
      end
   end

   // Divider restarts on every select write with PSTRB[0] set
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         restart_r  <= 1'b0;
         div_cnt_r  <= 5'h00;
         SYS_CLK_EN <= 1'b0;
      end else begin
         restart_r  <= wr_en & hit_clksel;
         div_cnt_r  <= div_cnt_nxt;
         SYS_CLK_EN <= pulse_nxt;
      end
   end

endmodule

// [scs_clock_ctrl_assertions.sv]
`timescale 1ns/1ps
module scs_clock_ctrl_assertions #(
   parameter int ADDR_W = 8
) (
   input wire logic              CLOCK,            // clock
   input wire logic              RST,              // reset
   input wire logic              PSEL,             // select
   input wire logic              PENABLE,          // access
   input wire logic              PWRITE,           // direction
   input wire logic [ADDR_W-1:0] PADDR,            // address
   input wire logic [31:0]       PWDATA,           // write data
   input wire logic [3:0]        PSTRB,            // strobes
   input wire logic              PREADY,           // ready
   input wire logic [31:0]       PRDATA,           // read data
   input wire logic              PSLVERR,          // error
   input wire logic [2:0]        BOOT_OPT,         // strap
   input wire logic              FAST_RC_EN,       // fast enable
   input wire logic              SLOW_RC_EN,       // slow enable
   input wire logic              XTAL_EN,          // crystal enable
   input wire logic [1:0]        XTAL_DRIVE,       // drive
   input wire logic              XTAL_LOW_CURRENT, // low current
   input wire logic              WDT_EN,           // watchdog
   input wire logic              FAST_RC_CAL,      // calibrated
   input wire logic [1:0]        SYS_SRC,          // source
   input wire logic              SYS_CLK_EN        // clock pulse
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   logic wr_acc;
   logic wr_sel;
   logic wr_xtal;
   assign wr_acc = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
   assign wr_sel = wr_acc && PADDR[7:0] == 8'h0c;
   assign wr_xtal = wr_acc && PADDR[7:0] == 8'h2c;
   property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
   a_ready: assert property (p_ready) else $error("Ready not single after setup");
   property p_err; PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0); endproperty
   a_err: assert property (p_err) else $error("Bad error response");
   property p_slow; wr_sel |=> ##1 SLOW_RC_EN == $past(PWDATA[2], 2); endproperty
   a_slow: assert property (p_slow) else $error("Slow enable wrong");
   property p_fast;
      wr_sel && PWDATA[7:0] inside {8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c}
         |=> ##1 SYS_SRC == 2'd1 && FAST_RC_EN;
   endproperty
   a_fast: assert property (p_fast) else $error("Fast source not taken");
   property p_xsel; wr_sel && PWDATA[7:0] == 8'ha4 |=> ##1 SYS_SRC == 2'd2; endproperty
   a_xsel: assert property (p_xsel) else $error("Crystal source not taken");
   property p_xtal;
      wr_xtal |=> ##1 XTAL_EN == $past(PWDATA[7], 2) && XTAL_DRIVE == $past(PWDATA[6:5], 2);
   endproperty
   a_xtal: assert property (p_xtal) else $error("Crystal control wrong");
   property p_low; XTAL_LOW_CURRENT |-> XTAL_EN; endproperty
   a_low: assert property (p_low) else $error("Low current without crystal");
   property p_bfast;
      $past(RST) && BOOT_OPT < 3'd5
         |=> ##1 !WDT_EN && SLOW_RC_EN && FAST_RC_EN && SYS_SRC == 2'd1 && !XTAL_EN;
   endproperty
   a_bfast: assert property (p_bfast) else $error("Fast boot state wrong");
   property p_bnone;
      $past(RST) && BOOT_OPT > 3'd5
         |=> ##1 WDT_EN && SLOW_RC_EN && !FAST_RC_EN && SYS_SRC == 2'd0 && !FAST_RC_CAL;
   endproperty
   a_bnone: assert property (p_bnone) else $error("Plain boot state wrong");
   property p_pulse; SYS_CLK_EN |=> !SYS_CLK_EN; endproperty
   a_pulse: assert property (p_pulse) else $error("Clock pulse too long");
endmodule

bind scs_clock_ctrl scs_clock_ctrl_assertions #(.ADDR_W(ADDR_W)) i_chk (
   .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
   .PSLVERR(PSLVERR), .BOOT_OPT(BOOT_OPT), .FAST_RC_EN(FAST_RC_EN),
   .SLOW_RC_EN(SLOW_RC_EN), .XTAL_EN(XTAL_EN), .XTAL_DRIVE(XTAL_DRIVE),
   .XTAL_LOW_CURRENT(XTAL_LOW_CURRENT), .WDT_EN(WDT_EN), .FAST_RC_CAL(FAST_RC_CAL),
   .SYS_SRC(SYS_SRC), .SYS_CLK_EN(SYS_CLK_EN));

// [scs_pkg.sv]
package scs_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CLKSEL_IDX    = 8'h03;
   localparam logic [7:0] MISC_IDX      = 8'h08;
   localparam logic [7:0] XTAL_CTRL_IDX = 8'h0b;
   localparam logic [7:0] STATUS_IDX    = 8'h0c;

   // Reset values
   localparam logic [7:0] CLKSEL_RST    = 8'hf4;
   localparam logic [7:0] XTAL_CTRL_RST = 8'h00;
   localparam logic [7:0] MISC_RST      = 8'h00;

   // Field positions
   localparam int CLKSEL_FAST_EN  = 4;
   localparam int CLKSEL_SLOW_EN  = 2;
   localparam int XTAL_EN_BIT     = 7;
   localparam int XTAL_DRV_HI     = 6;
   localparam int XTAL_DRV_LO     = 5;
   localparam int MISC_LOWCUR_BIT = 6;
   localparam int MISC_WDT_BIT    = 1;

   // Source/divider key formed from clock select bits {7:5,3}
   localparam logic [3:0] KEY_FAST_DIV2  = 4'h2;
   localparam logic [3:0] KEY_FAST_DIV4  = 4'h0;
   localparam logic [3:0] KEY_FAST_DIV8  = 4'h3;
   localparam logic [3:0] KEY_FAST_DIV16 = 4'h1;
   localparam logic [3:0] KEY_FAST_DIV32 = 4'h7;
   localparam logic [3:0] KEY_SLOW       = 4'he;
   localparam logic [3:0] KEY_XTAL       = 4'ha;

   // Divide ratios
   localparam logic [5:0] DIV_1  = 6'h01;
   localparam logic [5:0] DIV_2  = 6'h02;
   localparam logic [5:0] DIV_4  = 6'h04;
   localparam logic [5:0] DIV_8  = 6'h08;
   localparam logic [5:0] DIV_16 = 6'h10;
   localparam logic [5:0] DIV_32 = 6'h20;

   // Boot calibration strap codes and the clock select they load
   localparam logic [2:0] BOOT_FAST_DIV2  = 3'h0;
   localparam logic [2:0] BOOT_FAST_DIV4  = 3'h1;
   localparam logic [2:0] BOOT_FAST_DIV8  = 3'h2;
   localparam logic [2:0] BOOT_FAST_DIV16 = 3'h3;
   localparam logic [2:0] BOOT_FAST_DIV32 = 3'h4;
   localparam logic [2:0] BOOT_SLOW       = 3'h5;
   localparam logic [7:0] SEL_FAST_DIV2   = 8'h34;
   localparam logic [7:0] SEL_FAST_DIV4   = 8'h14;
   localparam logic [7:0] SEL_FAST_DIV8   = 8'h3c;
   localparam logic [7:0] SEL_FAST_DIV16  = 8'h1c;
   localparam logic [7:0] SEL_FAST_DIV32  = 8'h7c;
   localparam logic [7:0] SEL_SLOW        = 8'he4;

   // Status register fields
   localparam int STAT_SRC_LO   = 0;
   localparam int STAT_DIV_LO   = 2;
   localparam int STAT_STOPPED  = 5;
   localparam int STAT_BOOTED   = 6;
   localparam int STAT_FAST_CAL = 7;

   typedef enum logic [1:0] {SRC_SLOW, SRC_FAST, SRC_XTAL} scs_src_t;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction

endpackage

// [system_clock_source_control_tb.sv]
`timescale 1ns/1ps
module system_clock_source_control_tb;
   typedef struct packed {logic [7:0] sel; logic [1:0] src; logic [2:0] code;
                          logic fen; logic sen; int per;} scs_row_t;
   // Pulse spacing: fast 10, slow 50, crystal 20 cycles per period
   scs_row_t    rows [10] = '{'{8'h34, 2'd1, 3'd1, 1'b1, 1'b1, 20},
      '{8'h14, 2'd1, 3'd2, 1'b1, 1'b1, 40}, '{8'h3c, 2'd1, 3'd3, 1'b1, 1'b1, 80},
      '{8'h1c, 2'd1, 3'd4, 1'b1, 1'b1, 160}, '{8'h7c, 2'd1, 3'd5, 1'b1, 1'b1, 320},
      '{8'hf4, 2'd0, 3'd0, 1'b1, 1'b1, 50}, '{8'he4, 2'd0, 3'd0, 1'b0, 1'b1, 50},
      '{8'ha6, 2'd2, 3'd6, 1'b0, 1'b1, 20}, '{8'hb0, 2'd2, 3'd6, 1'b1, 1'b0, 20},
      '{8'ha4, 2'd2, 3'd6, 1'b0, 1'b1, 20}};
   logic [7:0]  bsel [8] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'hf4, 8'hf4};
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [2:0]  boot_opt = 3'h7;
   logic        fast_clk = 1'b0;
   logic        slow_clk = 1'b0;
   logic        xtal_clk = 1'b0;
   logic        pready, pslverr, fast_en, slow_en, xtal_en, low_cur, wdt_en, fast_cal, sys_clk_en;
   logic [31:0] prdata;
   logic [1:0]  xtal_drive, sys_src;
   logic [31:0] rd;
   logic        er;
   int          n;
   int          fail_count = 0;
   int          checks = 0;
   always #10 clock = ~clock;
   initial begin #3; forever #100 fast_clk = ~fast_clk; end
   initial begin #7; forever #500 slow_clk = ~slow_clk; end
   initial begin #5; forever #200 xtal_clk = ~xtal_clk; end
   scs_clock_ctrl i_dut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
      .PRDATA(prdata), .PSLVERR(pslverr), .BOOT_OPT(boot_opt), .FAST_RC_CLK(fast_clk),
      .SLOW_RC_CLK(slow_clk), .XTAL_CLK(xtal_clk), .FAST_RC_EN(fast_en), .SLOW_RC_EN(slow_en),
      .XTAL_EN(xtal_en), .XTAL_DRIVE(xtal_drive), .XTAL_LOW_CURRENT(low_cur), .WDT_EN(wdt_en),
      .FAST_RC_CAL(fast_cal), .SYS_SRC(sys_src), .SYS_CLK_EN(sys_clk_en));
   task automatic conclude;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         fail_count++;
         conclude();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'hf);
      repeat (2) @(posedge clock);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, 4'hf);
      chk(rd, {24'h0, e});
   endtask
   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (sys_clk_en !== 1'b1 && c < 3000);
      if (c >= 3000) begin
         fail_count++;
         conclude();
      end
   endtask
   task automatic boot(input logic [2:0] o);
      boot_opt <= o;
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      chk({fast_en, slow_en, xtal_en, wdt_en, sys_src, pready}, 7'b0101000);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   initial begin
      for (int o = 0; o < 8; o++) begin
         boot(3'(o));
         chk({wdt_en, slow_en, fast_en, xtal_en, sys_src, fast_cal},
             {o >= 5, 1'b1, o < 5, 1'b0, o < 5 ? 2'd1 : 2'd0, o < 6});
         rdc(8'h0c, bsel[o]);
         rdc(8'h2c, 8'h00);
      end
      for (int d = 1; d < 4; d++) begin
         wr(8'h2c, {1'b1, 2'(d), 5'h0});
         chk({xtal_en, xtal_drive}, {1'b1, 2'(d)});
         rdc(8'h2c, {1'b1, 2'(d), 5'h0});
      end
      // Crystal already enabled and running before it is selected
      // Row order turns an old source off only in a later write
      foreach (rows[i]) begin
         wr(8'h0c, rows[i].sel);
         chk({sys_src, fast_en, slow_en}, {rows[i].src, rows[i].fen, rows[i].sen});
         rdc(8'h0c, rows[i].sel);
         apb(1'b0, 8'h30, 8'h00, 4'hf);
         chk(rd[5:0], {1'b0, rows[i].code, rows[i].src});
         repeat (3) gap(n);
         chk(n, rows[i].per);
      end
      // Fast RC selected with its own enable bit clear: clock stops
      wr(8'h0c, 8'h24);
      apb(1'b0, 8'h30, 8'h00, 4'hf);
      chk(rd[5], 1'b1);
      n = 0;
      repeat (400) begin
         @(posedge clock);
         if (sys_clk_en !== 1'b0) n++;
      end
      chk(n, 0);
      apb(1'b1, 8'h0c, 8'h34, 4'he);
      rdc(8'h0c, 8'h24);
      apb(1'b0, 8'h04, 8'h00, 4'hf);
      chk({er, rd[7:0]}, 9'h100);
      wr(8'h20, 8'h42);
      chk({low_cur, wdt_en}, 2'b11);
      wr(8'h20, 8'h40);
      chk({low_cur, wdt_en}, 2'b10);
      // Crystal fully off before the device goes down
      wr(8'h2c, 8'h00);
      chk({low_cur, xtal_en}, 2'b00);
      rdc(8'h20, 8'h40);
      boot(3'd2);
      chk({sys_src, wdt_en}, 3'b010);
      conclude();
   end
endmodule
